/* core/serial_pkg.sv */
// constants and state types for the fifo serial port
// assumes one 25 MHz core clock; no register bus, settings arrive on ports
package serial_pkg;

  // ----------------------------------------------------------------
  // setting bit positions
  // ----------------------------------------------------------------
  localparam int MODE_CHR_BIT  = 6;   // char_length_select
  localparam int MODE_PE_BIT   = 5;   // parity_enable
  localparam int MODE_STOP_BIT = 3;   // two stop bits
  localparam int CTRL_CKE_BIT  = 1;   // clock_source_select

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int         CLK_HZ      = 25_000_000;
  localparam int         DATA_W      = 8;
  localparam int         FIFO_DEPTH  = 16;
  localparam int         BAUD_W      = 12;
  localparam logic [3:0] TICK_LAST   = 4'hf;  // 16 ticks per bit
  localparam logic [3:0] TICK_MID    = 4'h7;  // start check point
  localparam logic [2:0] LAST_BIT_8  = 3'h7;
  localparam logic [2:0] LAST_BIT_7  = 3'h6;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } rx_state_e;

endpackage : serial_pkg

/* core/fifo_if.sv */
// carrier between the serial port and its fifos
// assumes the fifo drives the store side and the port the user side
`timescale 1ns/1ps
interface fifo_if #(
  parameter int W = 8,
  parameter int D = 16
);
  logic                       wr_valid;
  logic                       wr_ready;
  logic [W-1:0]               wr_data;
  logic                       rd_valid;
  logic                       rd_ready;
  logic [W-1:0]               rd_data;
  logic [$clog2(D+1)-1:0]     count;

  modport store (input  wr_valid, wr_data, rd_ready,
                 output wr_ready, rd_valid, rd_data, count);
  modport user  (output wr_valid, wr_data, rd_ready,
                 input  wr_ready, rd_valid, rd_data, count);
endinterface : fifo_if

/* core/sync_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
// assumes an asynchronous active-low reset copy from the top module
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  fifo_if.store       f
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr, next_wr_ptr;
  logic [PW-1:0]    rd_ptr, next_rd_ptr;
  logic [CW-1:0]    count,  next_count;
  logic             push, pop;

  // ----------------------------------------------------------------
  // handshakes and pointers
  // ----------------------------------------------------------------
  assign f.wr_ready = (count != CW'(DEPTH));
  assign f.rd_valid = (count != '0);
  assign f.rd_data  = mem[rd_ptr];
  assign f.count    = count;
  assign push       = f.wr_valid && f.wr_ready;
  assign pop        = f.rd_valid && f.rd_ready;

  // next pointers, wrap at depth
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
    end
    if (push && !pop) begin
      next_count = count + 1'h1;
    end else if (pop && !push) begin
      next_count = count - 1'h1;
    end
  end

  // state registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= f.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fifo_full_stop:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    count == CW'(DEPTH) && !pop |=> count == CW'(DEPTH))
    else $error("fifo count moved past full");

  a_fifo_count_step:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    push && !pop |=> count == $past(count) + 1'h1)
    else $error("fifo count missed a push");
endmodule : sync_fifo

/* core/async_serial_fifo_port.sv */
// fifo serial port: async transmitter and receiver with modem lines
// assumes settings held stable while the port is disabled for change
//
// Summary of operation
// - resync to every start bit, asynchronous only
// - sixteen-entry fifo for each direction
// - active-low rts output, active-low cts input
// - mode bit 6: 0 eight, 1 seven bits
// - bit 5 adds parity; bit 3 two stops
// - start, data, optional parity, one/two stops
// - control bit 1 picks internal or external clock
// - internal: baud generator, clock pin ignored
// - external: pin timing, generator unused
// - flag framing, parity, full, overrun, ready, break
// - report byte counts of both fifos
// - data sent least significant bit first
// - line held at mark between frames
// - only first stop bit checked
// - overrun when frame ends with fifo full
`timescale 1ns/1ps
module async_serial_fifo_port
  import serial_pkg::*;
#(
  parameter int DEPTH       = serial_pkg::FIFO_DEPTH,
  parameter int RTS_TRIGGER = serial_pkg::FIFO_DEPTH - 1
) (
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic [7:0]                  serial_mode_register_in,
  input  wire logic [7:0]                  serial_control_register_in,
  input  wire logic                        parity_odd_in,
  input  wire logic                        tx_enable_in,
  input  wire logic                        rx_enable_in,
  input  wire logic                        modem_control_in,
  input  wire logic [serial_pkg::BAUD_W-1:0] baud_divisor_in,
  input  wire logic [serial_pkg::DATA_W-1:0] tx_data_in,
  input  wire logic                        tx_valid_in,
  output logic                             tx_ready_out,
  output logic [serial_pkg::DATA_W-1:0]    rx_data_out,
  output logic                             rx_framing_out,
  output logic                             rx_parity_out,
  output logic                             rx_valid_out,
  input  wire logic                        rx_ready_in,
  output logic [$clog2(DEPTH+1)-1:0]       tx_count_out,
  output logic [$clog2(DEPTH+1)-1:0]       rx_count_out,
  output logic                             serial_tx_out,
  input  wire logic                        serial_rx_in,
  output logic                             request_to_send_n_out,
  input  wire logic                        clear_to_send_n_in,
  input  wire logic                        external_serial_clock_pin_in,
  input  wire logic                        error_clear_in,
  output logic                             framing_error_out,
  output logic                             parity_error_out,
  output logic                             break_out,
  output logic                             overrun_error_flag_out,
  output logic                             rx_full_out,
  output logic                             rx_data_ready_out
);
  import serial_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);

  // last data bit index for the selected length
  function automatic logic [2:0] last_bit(input logic [7:0] mode);
    last_bit = mode[MODE_CHR_BIT] ? LAST_BIT_7 : LAST_BIT_8;
  endfunction : last_bit

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta, rst_n;

  // two-stage release of the async reset
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // sixteen-times bit tick
  // ----------------------------------------------------------------
  logic              cke, ext_prev, ext_edge, int_tick, tick16;
  logic [BAUD_W-1:0] baud_cnt, next_baud_cnt;

  assign cke      = serial_control_register_in[CTRL_CKE_BIT];
  assign ext_edge = external_serial_clock_pin_in && !ext_prev;
  assign int_tick = (baud_cnt == '0);
  // pick tick source; the unused one is ignored
  assign tick16   = cke ? ext_edge : int_tick;

  // divider reloads every divisor+1 cycles
  always_comb begin
    next_baud_cnt = int_tick ? baud_divisor_in : baud_cnt - 1'h1;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt <= '0;
      ext_prev <= 1'h0;
    end else begin
      baud_cnt <= next_baud_cnt;
      ext_prev <= external_serial_clock_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // fifos
  // ----------------------------------------------------------------
  fifo_if #(.W(DATA_W),     .D(DEPTH)) tx_q ();
  fifo_if #(.W(DATA_W + 2), .D(DEPTH)) rx_q ();

  sync_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) tx_fifo (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n),
    .f        (tx_q)
  );
  sync_fifo #(.WIDTH(DATA_W + 2), .DEPTH(DEPTH)) rx_fifo (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n),
    .f        (rx_q)
  );

  // user side of the fifos and counts
  assign tx_q.wr_valid  = tx_valid_in;
  assign tx_q.wr_data   = tx_data_in;
  assign tx_ready_out   = tx_q.wr_ready;
  assign rx_q.rd_ready  = rx_ready_in;
  assign rx_valid_out   = rx_q.rd_valid;
  assign rx_data_out    = rx_q.rd_data[DATA_W-1:0];
  assign rx_parity_out  = rx_q.rd_data[DATA_W];
  assign rx_framing_out = rx_q.rd_data[DATA_W+1];
  assign tx_count_out   = tx_q.count;
  assign rx_count_out   = rx_q.count;
  assign rx_full_out    = (rx_q.count == CW'(DEPTH));
  assign rx_data_ready_out = rx_q.rd_valid;

  // rts high when receive disabled or fifo near full
  assign request_to_send_n_out = !rx_enable_in || (modem_control_in &&
    rx_q.count >= CW'(RTS_TRIGGER));

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  tx_state_e   tx_state, next_tx_state;
  logic [3:0]  tx_tick,  next_tx_tick;
  logic [2:0]  tx_bit,   next_tx_bit;
  logic [7:0]  tx_shift, next_tx_shift;
  logic        tx_par,   next_tx_par;
  logic        tx_line,  next_tx_line;
  logic        tx_bit_end, cts_block;
  logic [7:0]  tx_load;

  assign tx_bit_end = tick16 && (tx_tick == TICK_LAST);
  assign cts_block  = modem_control_in && clear_to_send_n_in;
  assign tx_load    = serial_mode_register_in[MODE_CHR_BIT] ?
                      {1'h0, tx_q.rd_data[6:0]} : tx_q.rd_data;
  assign tx_q.rd_ready = (tx_state == TX_IDLE) && tx_enable_in &&
                         !cts_block;
  assign serial_tx_out = tx_line;

  // frame sequencing
  always_comb begin
    next_tx_state = tx_state;
    next_tx_tick  = tick16 ? tx_tick + 1'h1 : tx_tick;
    next_tx_bit   = tx_bit;
    next_tx_shift = tx_shift;
    next_tx_par   = tx_par;
    next_tx_line  = tx_line;
    unique case (tx_state)
      TX_IDLE: begin
        next_tx_line = 1'h1;
        if (tx_q.rd_valid && tx_q.rd_ready) begin
          next_tx_shift = tx_load;
          next_tx_par   = ^tx_load ^ parity_odd_in;
          next_tx_tick  = '0;
          next_tx_line  = 1'h0;
          next_tx_state = TX_START;
        end
      end
      TX_START: if (tx_bit_end) begin
        next_tx_state = TX_DATA;
        next_tx_bit   = '0;
        next_tx_line  = tx_shift[0];
      end
      TX_DATA: if (tx_bit_end) begin
        next_tx_shift = tx_shift >> 1;
        next_tx_bit   = tx_bit + 1'h1;
        next_tx_line  = tx_shift[1];
        if (tx_bit == last_bit(serial_mode_register_in)) begin
          if (serial_mode_register_in[MODE_PE_BIT]) begin
            next_tx_state = TX_PARITY;
            next_tx_line  = tx_par;
          end else begin
            next_tx_state = TX_STOP;
            next_tx_line  = 1'h1;
            next_tx_bit   = '0;
          end
        end
      end
      TX_PARITY: if (tx_bit_end) begin
        next_tx_state = TX_STOP;
        next_tx_line  = 1'h1;
        next_tx_bit   = '0;
      end
      TX_STOP: if (tx_bit_end) begin
        next_tx_bit = 3'h1;
        if (!(serial_mode_register_in[MODE_STOP_BIT] &&
              tx_bit == '0)) begin
          next_tx_state = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_tick  <= '0;
      tx_bit   <= '0;
      tx_shift <= '0;
      tx_par   <= 1'h0;
      tx_line  <= 1'h1;
    end else begin
      tx_state <= next_tx_state;
      tx_tick  <= next_tx_tick;
      tx_bit   <= next_tx_bit;
      tx_shift <= next_tx_shift;
      tx_par   <= next_tx_par;
      tx_line  <= next_tx_line;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  rx_state_e   rx_state, next_rx_state;
  logic [3:0]  rx_tick,  next_rx_tick;
  logic [2:0]  rx_bit,   next_rx_bit;
  logic [7:0]  rx_shift, next_rx_shift;
  logic        rx_par,   next_rx_par;
  logic        rx_perr,  next_rx_perr;
  logic        rx_sample, rx_done, rx_fer, rx_brk;
  logic [7:0]  rx_word;

  assign rx_sample = tick16 && (rx_tick == TICK_LAST);
  assign rx_word   = serial_mode_register_in[MODE_CHR_BIT] ?
                     {1'h0, rx_shift[7:1]} : rx_shift;
  assign rx_done   = (rx_state == RX_STOP) && rx_sample;
  assign rx_fer    = !serial_rx_in;
  assign rx_brk    = rx_fer && (rx_word == '0);
  assign rx_q.wr_valid = rx_done && rx_enable_in &&
                         !overrun_error_flag_out;
  assign rx_q.wr_data  = {rx_fer, rx_perr, rx_word};

  // frame capture, restarted by each start bit
  always_comb begin
    next_rx_state = rx_state;
    next_rx_tick  = tick16 ? rx_tick + 1'h1 : rx_tick;
    next_rx_bit   = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_par   = rx_par;
    next_rx_perr  = rx_perr;
    unique case (rx_state)
      RX_IDLE: if (tick16 && !serial_rx_in && rx_enable_in) begin
        next_rx_state = RX_START;
        next_rx_tick  = '0;
      end
      RX_START: if (tick16 && rx_tick == TICK_MID) begin
        next_rx_tick  = '0;
        next_rx_bit   = '0;
        next_rx_par   = parity_odd_in;
        next_rx_perr  = 1'h0;
        next_rx_state = serial_rx_in ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rx_sample) begin
        next_rx_shift = {serial_rx_in, rx_shift[7:1]};
        next_rx_par   = rx_par ^ serial_rx_in;
        next_rx_bit   = rx_bit + 1'h1;
        if (rx_bit == last_bit(serial_mode_register_in)) begin
          next_rx_state = serial_mode_register_in[MODE_PE_BIT] ?
                          RX_PARITY : RX_STOP;
        end
      end
      RX_PARITY: if (rx_sample) begin
        next_rx_perr  = rx_par ^ serial_rx_in;
        next_rx_state = RX_STOP;
      end
      RX_STOP: if (rx_sample) begin
        next_rx_state = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_tick  <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_par   <= 1'h0;
      rx_perr  <= 1'h0;
    end else begin
      rx_state <= next_rx_state;
      rx_tick  <= next_rx_tick;
      rx_bit   <= next_rx_bit;
      rx_shift <= next_rx_shift;
      rx_par   <= next_rx_par;
      rx_perr  <= next_rx_perr;
    end
  end

  // ----------------------------------------------------------------
  // sticky receive flags, set wins over clear
  // ----------------------------------------------------------------
  logic next_fer, next_per, next_brk, next_ovr;

  always_comb begin
    next_fer = (rx_done && rx_fer) ||
               (framing_error_out && !error_clear_in);
    next_per = (rx_done && rx_perr) ||
               (parity_error_out && !error_clear_in);
    next_brk = (rx_done && rx_brk) || (break_out && !error_clear_in);
    next_ovr = (rx_q.wr_valid && !rx_q.wr_ready) ||
               (overrun_error_flag_out && !error_clear_in);
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      framing_error_out      <= 1'h0;
      parity_error_out       <= 1'h0;
      break_out              <= 1'h0;
      overrun_error_flag_out <= 1'h0;
    end else begin
      framing_error_out      <= next_fer;
      parity_error_out       <= next_per;
      break_out              <= next_brk;
      overrun_error_flag_out <= next_ovr;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start_done;
    tx_state == TX_START && tx_bit_end;
  endsequence

  sequence s_full_done;
    rx_q.wr_valid && rx_q.count == CW'(DEPTH);
  endsequence

  a_tx_idle_mark:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    tx_state == TX_IDLE |-> serial_tx_out)
    else $error("line left mark while idle");

  a_tx_start_low:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(tx_state == TX_START) |-> !serial_tx_out)
    else $error("start bit not low");

  a_tx_lsb_first:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    s_start_done |=> serial_tx_out == $past(tx_shift[0]))
    else $error("first data bit not lsb");

  a_cts_holds_idle:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    tx_state == TX_IDLE && cts_block |=> tx_state == TX_IDLE)
    else $error("frame started while cts high");

  a_rts_near_full:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    modem_control_in && rx_q.count >= CW'(RTS_TRIGGER)
      |-> request_to_send_n_out)
    else $error("rts low with fifo near full");

  a_overrun_set:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    s_full_done |=> overrun_error_flag_out ##1
      (overrun_error_flag_out || $past(error_clear_in)))
    else $error("overrun not flagged");

  a_ext_tick_only:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    cke && tick16 |-> external_serial_clock_pin_in && !ext_prev)
    else $error("tick without clock pin edge");

  a_flag_sticky:
  assert property (@(posedge core_clk_in) disable iff (!rst_n)
    framing_error_out && !error_clear_in |=> framing_error_out)
    else $error("framing flag lost");
endmodule : async_serial_fifo_port

/* testbench/remote_serial_model.sv */
// remote serial device: sends and samples frames, drives clock pin and cts
// assumes the bench calls its tasks just after a core clock edge
`timescale 1ns/1ps
module remote_serial_model (
  input  wire logic line_in,
  output logic      line_out,
  output logic      clk_pin_out,
  output logic      cts_n_out
);
  int bit_ns = 1280;

  // ----------------------------------------------------------------
  // idle levels and free running clock pin
  // ----------------------------------------------------------------
  // pin period of four core cycles, never stopped while in use
  initial begin
    line_out    = 1'b1;
    cts_n_out   = 1'b0;
    clk_pin_out = 1'b0;
    forever #80 clk_pin_out = ~clk_pin_out;
  end

  // ----------------------------------------------------------------
  // line tasks
  // ----------------------------------------------------------------
  // drive 13 bit slots, slot 0 first; trailing ones are mark
  task automatic send(input logic [12:0] f);
    for (int i = 0; i < 13; i++) begin
      line_out = f[i];
      #(bit_ns);
    end
  endtask : send

  // short low pulse, too short to be a start bit
  task automatic pulse(input int ns);
    line_out = 1'b0;
    #(ns);
    line_out = 1'b1;
  endtask : pulse

  // bounded wait for a start edge, then sample 13 slot centres
  task automatic recv(output logic [12:0] f, output bit late);
    int k;
    k = 0;
    f = '1;
    while (line_in !== 1'b0 && k < 100000) begin
      #10;
      k++;
    end
    late = (k >= 100000);
    #(bit_ns / 2);
    for (int i = 0; i < 13; i++) begin
      f[i] = line_in;
      #(bit_ns);
    end
  endtask : recv
endmodule : remote_serial_model

/* testbench/tb_async_serial_fifo_port.sv */
// self-checking bench for the fifo serial port
// assumes the remote model on the line side and a 25 MHz core clock
`timescale 1ns/1ps
module tb_async_serial_fifo_port;
  import serial_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic core_clk_in, rst_b_in, parity_odd_in, tx_enable_in, rx_enable_in;
  logic modem_control_in, tx_valid_in, rx_ready_in, error_clear_in;
  logic tx_ready_out, rx_framing_out, rx_parity_out, rx_valid_out;
  logic serial_tx_out, serial_rx_in, request_to_send_n_out, ext_pin;
  logic clear_to_send_n_in, framing_error_out, parity_error_out;
  logic break_out, overrun_error_flag_out, rx_full_out, rx_data_ready_out;
  logic [7:0]        mode, ctrl, tx_data_in, rx_data_out;
  logic [BAUD_W-1:0] baud_divisor_in;
  logic [4:0]        tx_count_out, rx_count_out;
  logic [3:0]        flg;
  logic [12:0]       f;
  logic [9:0]        w;
  int                failures = 0;
  int                cmp_count = 0;

  assign flg = {framing_error_out, parity_error_out, break_out,
                overrun_error_flag_out};

  async_serial_fifo_port dut (
    .core_clk_in, .rst_b_in, .serial_mode_register_in(mode),
    .serial_control_register_in(ctrl), .parity_odd_in, .tx_enable_in,
    .rx_enable_in, .modem_control_in, .baud_divisor_in, .tx_data_in,
    .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_framing_out,
    .rx_parity_out, .rx_valid_out, .rx_ready_in, .tx_count_out,
    .rx_count_out, .serial_tx_out, .serial_rx_in, .request_to_send_n_out,
    .clear_to_send_n_in, .external_serial_clock_pin_in(ext_pin),
    .error_clear_in, .framing_error_out, .parity_error_out, .break_out,
    .overrun_error_flag_out, .rx_full_out, .rx_data_ready_out
  );

  remote_serial_model rs (
    .line_in(serial_tx_out), .line_out(serial_rx_in),
    .clk_pin_out(ext_pin), .cts_n_out(clear_to_send_n_in)
  );

  // 40 ns core clock
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  // expected line slots for the current mode; nxt adds the queued ~d frame
  function automatic logic [12:0] frame(input logic [7:0] d,
                                        input logic nxt);
    int   k;
    logic p;
    frame = '1;
    frame[0] = 1'b0;
    p = parity_odd_in;
    k = mode[6] ? 7 : 8;
    for (int i = 0; i < k; i++) begin
      frame[i + 1] = d[i];
      p = p ^ d[i];
    end
    k = k + 1;
    if (mode[5]) begin
      frame[k] = p;
      k = k + 1;
    end
    // queued byte follows at once: its start and first data bits
    if (nxt) begin
      k = k + 1 + int'(mode[3]);
      frame[k] = 1'b0;
      for (int i = k + 1; i < 13; i++) frame[i] = ~d[i - k - 1];
    end
  endfunction : frame

  task automatic push(input logic [7:0] d);
    int k;
    k = 0;
    tx_data_in = d;
    tx_valid_in = 1'b1;
    while (tx_ready_out !== 1'b1 && k < 100) begin
      step(1);
      k++;
    end
    if (k == 100) begin
      failures++;
      summarize();
    end
    step(1);
    tx_valid_in = 1'b0;
    step(1);
  endtask : push

  task automatic pop(output logic [9:0] v);
    int k;
    k = 0;
    while (rx_valid_out !== 1'b1 && k < 50) begin
      step(1);
      k++;
    end
    if (k == 50) begin
      failures++;
      summarize();
    end
    v = {rx_framing_out, rx_parity_out, rx_data_out};
    rx_ready_in = 1'b1;
    step(1);
    rx_ready_in = 1'b0;
    step(1);
  endtask : pop

  // two queued bytes out, one frame in
  task automatic roundtrip(input logic [7:0] d);
    logic [9:0] mk;
    bit         late;
    mk = mode[6] ? 10'h37f : 10'h3ff;
    push(d);
    push(~d);
    rs.recv(f, late);
    if (late) begin
      failures++;
      summarize();
    end
    step(1);
    check(16'(f), 16'(frame(d, 1'b1)));
    rs.send(frame(d, 1'b0));
    step(2);
    pop(w);
    check(16'(w & mk), 16'({2'b00, d} & mk));
  endtask : roundtrip

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b_in, parity_odd_in, tx_enable_in, rx_enable_in} = 4'b0011;
    {modem_control_in, tx_valid_in, rx_ready_in, error_clear_in} = 4'b0;
    {mode, ctrl, tx_data_in} = '0;
    baud_divisor_in = 12'h001;
    step(10);
    rst_b_in = 1'b1;
    step(3);
    check(16'({serial_tx_out, tx_ready_out, rx_valid_out, flg}), 16'h0060);
    // every format, internal clock with the pin running
    for (int m = 0; m < 8; m++) begin
      mode = {1'b0, m[2], m[1], 1'b0, m[0], 3'b000};
      parity_odd_in = m[0] ^ m[2];
      roundtrip(8'h5a ^ 8'(m * 37));
    end
    $display("test formats done");
    // parity, framing and break frames
    mode = 8'h20;
    parity_odd_in = 1'b0;
    for (int i = 0; i < 3; i++) begin
      f = (i == 0) ? frame(8'h3c, 1'b0) ^ 13'h0200 :
          (i == 1) ? frame(8'h5a, 1'b0) ^ 13'h0400 : 13'h1800;
      rs.send(f);
      step(2);
      pop(w);
      check(16'(w), 16'(i == 0 ? 10'h13c : i == 1 ? 10'h25a : 10'h200));
      check(16'(flg), 16'(i == 0 ? 4'h4 : i == 1 ? 4'h8 : 4'ha));
      error_clear_in = 1'b1;
      step(1);
      error_clear_in = 1'b0;
      check(16'(flg), 16'h0000);
    end
    // bad second stop forms a new start; a short pulse is dropped
    mode = 8'h08;
    rs.send(frame(8'h66, 1'b0) ^ 13'h0400);
    step(400);
    pop(w);
    check(16'({w, flg}), 16'h0660);
    pop(w);
    check(16'(w), 16'h00ff);
    rs.pulse(200);
    step(600);
    check(16'(rx_count_out), 16'h0000);
    $display("test errors done");
    // fill both fifos, cts hold-off, rts threshold, overrun
    mode = 8'h00;
    tx_enable_in = 1'b0;
    for (int i = 0; i < 16; i++) push(8'(i));
    check(16'({tx_count_out, tx_ready_out}), 16'h0020);
    modem_control_in = 1'b1;
    rs.cts_n_out = 1'b1;
    tx_enable_in = 1'b1;
    step(100);
    check(16'({serial_tx_out, tx_count_out}), 16'h0030);
    rs.cts_n_out = 1'b0;
    step(8);
    check(16'(tx_count_out), 16'h000f);
    for (int i = 0; i < 17; i++) begin
      rs.send(frame(8'(i + 1), 1'b0));
      step(1);
      if (i == 13) check(16'({request_to_send_n_out, rx_count_out}), 16'h000e);
      if (i == 14) check(16'({request_to_send_n_out, rx_count_out}), 16'h002f);
    end
    check(16'({rx_full_out, rx_data_ready_out, rx_count_out, flg}), 16'h0701);
    check(16'({tx_count_out, serial_tx_out}), 16'h0001);
    for (int i = 0; i < 16; i++) begin
      pop(w);
      check(16'(w), 16'(i + 1));
    end
    check(16'(rx_count_out), 16'h0000);
    rx_enable_in = 1'b0;
    step(1);
    check(16'(request_to_send_n_out), 16'h0001);
    rx_enable_in = 1'b1;
    error_clear_in = 1'b1;
    step(1);
    error_clear_in = 1'b0;
    $display("test fifos done");
    // external clock pin; the divider is set to a misleading rate
    ctrl = 8'h02;
    baud_divisor_in = 12'h005;
    rs.bit_ns = 2560;
    roundtrip(8'hc3);
    $display("test external clock done");
    summarize();
  end
endmodule : tb_async_serial_fifo_port
